// file: core/slc_link_core.sv
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/100ps
module slc_link_core
  import slc_pkg::*;
(
  // system
  input  wire logic        clk,
  input  wire logic        rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  output logic             irq,
  // host transmit port
  input  wire logic        tx_fifo_clock,
  input  wire logic        reference_clock_in,
  input  wire logic        tx_write_en,
  input  wire logic        tx_command_data_select,
  input  wire logic [9:0]  tx_data_bits,
  input  wire logic [1:0]  tx_command_bits,
  output logic             tx_full,
  // host receive port
  input  wire logic        rx_fifo_clock,
  input  wire logic        rx_read_en,
  output logic [11:0]      rx_char_bits,
  output logic             rx_command_flag,
  output logic             rx_char_err,
  output logic             rx_char_valid,
  output logic             rx_empty,
  // serial line
  output logic             serial_out,
  input  wire logic        rx_line_a,
  input  wire logic        rx_line_b
);
  typedef struct packed {
    logic [19:0]   sy1;
    logic [19:0]   sy2;
    logic [2:0]    clk_d;
    logic [5:0]    ctrl;
    logic          clr;
    logic [3:0]    stat;
    logic [3:0]    mask;
    logic          irq;
    logic          pready;
    logic          pslverr;
    logic [31:0]   prdata;
    logic          tx_full;
    logic [CW-1:0] txh;
    logic          txh_v;
    slc_ser_type   ser;
    logic [11:0]   tsh;
    logic [3:0]    tcnt;
    logic [1:0]    div;
    logic          line;
    logic [9:0]    pat;
    logic          rx_prev;
    logic [11:0]   rsh;
    logic [3:0]    rcnt;
    slc_frame_type fr;
    logic [9:0]    expv;
    logic [7:0]    errcnt;
    logic          chk_arm;
    logic [EW-1:0] rxo;
    logic          rxo_v;
    logic          rx_empty;
  } slc_core_st_type;

  localparam slc_core_st_type CORE_RST = '{ctrl: CTRL_RST, ser: SER_IDLE, fr: FR_HUNT,
    rx_empty: 1'b1, default: '0};

  // one-hot register select: level, mask, status, control
  function automatic logic [3:0] reg_sel(input logic [7:0] a);
    reg_sel = {a == ADDR_LEVEL, a == ADDR_MASK, a == ADDR_STAT, a == ADDR_CTRL};
  endfunction : reg_sel

  slc_core_st_type s_r;
  slc_core_st_type s_nxt;

  logic          w8;
  logic          coded;
  logic          fifo_on;
  logic          fast;
  logic          built_in_pattern_test;
  logic [3:0]    clen_m1;
  logic [9:0]    pmask;
  logic [3:0]    rsel;
  logic          setup;
  logic          wr_acc;
  logic          tx_edge;
  logic          ref_edge;
  logic          rx_edge;
  logic          bit_en;
  logic          load;
  logic          line_in;
  logic [CW-1:0] cap;
  logic [CW-1:0] enc_in;
  logic          have;
  logic [11:0]   enc_code;
  logic [11:0]   rsh_n;
  logic [11:0]   dec_code;
  logic [CW-1:0] dec_char;
  logic          dec_err;
  logic          dec_idle;
  logic          done;
  logic          got;
  logic          tf_wv;
  logic          tf_wr;
  logic          tf_rv;
  logic [EW-1:0] tf_rd;
  logic          tf_rr;
  logic          rf_wr;
  logic          rf_rv;
  logic [EW-1:0] rf_rd;
  logic          rf_rr;
  logic [3:0]    ev;
  logic [11:0]   tnext;

  // mode fields
  assign w8      = s_r.ctrl[CB_W8];
  assign coded   = s_r.ctrl[CB_CODE_N];
  assign fifo_on = s_r.ctrl[CB_FIFO_N];
  assign fast    = s_r.ctrl[CB_FAST];
  assign built_in_pattern_test    = s_r.ctrl[CB_BUILT_IN_PATTERN_TEST];
  assign clen_m1 = w8 ? 4'(LEN8 - 1) : 4'(LEN10 - 1);
  assign pmask   = w8 ? PAT_MASK8 : PAT_MASK10;

  // apb phases; pready comes one cycle after setup
  assign rsel   = reg_sel(paddr);
  assign setup  = psel && !penable;
  assign wr_acc = psel && penable && s_r.pready && pwrite;

  // edges of the pin clocks, read from the second synchroniser stage
  assign tx_edge  = s_r.sy2[SY_TX_FIFO_CLOCK] && !s_r.clk_d[0];
  assign ref_edge = s_r.sy2[SY_TX_FIFO_CLOCK+1] && !s_r.clk_d[1];
  assign rx_edge  = s_r.sy2[SY_RXCLK] && !s_r.clk_d[2];
  assign cap      = {s_r.sy2[SY_SEL], s_r.sy2[11:0]};

  // bit pacing and character boundary
  assign bit_en = (s_r.div == 2'h0);
  assign load   = bit_en && (s_r.tcnt == 4'h0);

  // transmit source: pattern, fifo head or reference-locked holding register
  // pattern slots alternate with idles, else the far receiver never frames
  assign have   = built_in_pattern_test ? (s_r.ser != SER_CHAR) : (fifo_on ? tf_rv : s_r.txh_v);
  assign enc_in = built_in_pattern_test ? {3'h0, s_r.pat & pmask} : (fifo_on ? tf_rd[CW-1:0] : s_r.txh);
  assign tf_wv  = fifo_on && tx_edge && s_r.sy2[SY_WR];
  assign tf_rr  = load && fifo_on && !built_in_pattern_test;

  // receive front end
  assign line_in  = s_r.ctrl[CB_LINE] ? s_r.sy2[SY_LB] : s_r.sy2[SY_LA];
  assign rsh_n    = {s_r.rsh[10:0], line_in ^ s_r.rx_prev};
  assign dec_code = w8 ? {2'h0, rsh_n[9:0]} : rsh_n;
  assign done     = bit_en && (s_r.fr == FR_LOCK) && !dec_idle && (s_r.rcnt == clen_m1);
  assign got      = done && !built_in_pattern_test;
  assign rf_rr    = fifo_on && rx_edge && s_r.sy2[SY_RD];

  always_comb
  begin
    s_nxt = s_r;
    ev    = 4'h0;
    tnext = s_r.tsh;
    // first stage is read only by the second
    s_nxt.sy1   = {rx_fifo_clock, reference_clock_in, tx_fifo_clock, rx_line_b, rx_line_a,
                   rx_read_en, tx_write_en, tx_command_data_select, tx_command_bits,
                   tx_data_bits};
    s_nxt.sy2   = s_r.sy1;
    s_nxt.clk_d = s_r.sy2[SY_RXCLK:SY_TX_FIFO_CLOCK];

    // apb answer and register writes
    s_nxt.pready  = setup;
    s_nxt.pslverr = setup && !(|rsel);
    if (setup)
      s_nxt.prdata = ({32{rsel[0]}} & 32'(s_r.ctrl)) | ({32{rsel[1]}} & 32'(s_r.stat))
        | ({32{rsel[2]}} & 32'(s_r.mask))
        | ({32{rsel[3]}} & 32'({s_r.errcnt, 4'h0, s_r.fr == FR_LOCK, s_r.ser == SER_CHAR,
                                s_r.rx_empty, s_r.tx_full}));
    s_nxt.clr = 1'b0;
    if (wr_acc && rsel[0])
    begin
      s_nxt.ctrl = pwdata[5:0];
      s_nxt.clr  = pwdata[CB_CLR];
    end
    if (wr_acc && rsel[2])
      s_nxt.mask = pwdata[3:0];

    // transmit capture; holding register empties when the serializer takes it
    s_nxt.tx_full = !tf_wr;
    ev[SB_TXOVF]  = tf_wv && !tf_wr;
    if (load && !fifo_on && !built_in_pattern_test)
      s_nxt.txh_v = 1'b0;
    if (!fifo_on && ref_edge && s_r.sy2[SY_WR])
    begin
      s_nxt.txh   = cap;
      s_nxt.txh_v = 1'b1;
    end

    // serializer with nrzi: a one toggles the line
    s_nxt.div = bit_en ? (fast ? DIV_X20 : DIV_X10) : s_r.div - 2'h1;
    if (bit_en)
    begin
      if (s_r.tcnt == 4'h0)
      begin
        tnext      = w8 ? {enc_code[9:0], 2'h0} : enc_code;
        s_nxt.tcnt = clen_m1;
        s_nxt.ser  = have ? SER_CHAR : SER_IDLE;
        if (built_in_pattern_test && have)
          s_nxt.pat = s_r.pat + 10'h001;
      end
      else
      begin
        tnext      = {s_r.tsh[10:0], 1'b0};
        s_nxt.tcnt = s_r.tcnt - 4'h1;
      end
      s_nxt.tsh  = tnext;
      s_nxt.line = s_r.line ^ tnext[11];
    end

    // framing: an idle character fixes the boundary
    if (bit_en)
    begin
      s_nxt.rx_prev = line_in;
      s_nxt.rsh     = rsh_n;
      if (dec_idle)
      begin
        s_nxt.fr   = FR_LOCK;
        s_nxt.rcnt = 4'h0;
      end
      else if (s_r.rcnt == clen_m1)
        s_nxt.rcnt = 4'h0;
      else
        s_nxt.rcnt = s_r.rcnt + 4'h1;
    end
    ev[SB_CERR]  = done && dec_err;
    ev[SB_RXOVF] = got && fifo_on && !rf_wr;

    // checker resynchronises on every value; the first after a clear is only adopted
    if (done && built_in_pattern_test && !dec_char[12])
    begin
      s_nxt.chk_arm = 1'b1;
      if (s_r.chk_arm && ((dec_char[9:0] & pmask) != s_r.expv))
      begin
        ev[SB_PERR] = 1'b1;
        if (s_r.errcnt != 8'hff)
          s_nxt.errcnt = s_r.errcnt + 8'h01;
      end
      s_nxt.expv = (dec_char[9:0] + 10'h001) & pmask;
    end

    // receive port: fifo read strobe or pipeline register
    if (fifo_on)
    begin
      if (rf_rr)
      begin
        s_nxt.rxo   = rf_rd;
        s_nxt.rxo_v = rf_rv;
      end
    end
    else
    begin
      s_nxt.rxo_v = got;
      if (got)
        s_nxt.rxo = {dec_err, dec_char};
    end
    s_nxt.rx_empty = !rf_rv;

    // clear: framing lost, holding register dropped, idle goes out unless the pattern test is on
    if (s_r.clr)
    begin
      s_nxt.txh_v = 1'b0;
      s_nxt.fr    = FR_HUNT;
      s_nxt.rcnt  = 4'h0;
      s_nxt.rxo_v = 1'b0;
      s_nxt.chk_arm = 1'b0;
    end

    // sticky status, an event in the clearing cycle wins
    s_nxt.stat = (s_r.stat & ~((wr_acc && rsel[1]) ? pwdata[3:0] : 4'h0)) | ev;
    s_nxt.irq  = |(s_nxt.stat & s_nxt.mask);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      s_r <= CORE_RST;
    else
      s_r <= s_nxt;
  end

  // transmit fifo
  slc_fifo u_tx_fifo
  (
    .clk      (clk),
    .rst      (rst),
    .clr      (s_r.clr),
    .wr_valid (tf_wv),
    .wr_data  ({1'b0, cap}),
    .wr_ready (tf_wr),
    .rd_valid (tf_rv),
    .rd_data  (tf_rd),
    .rd_ready (tf_rr)
  );

  // receive fifo
  slc_fifo u_rx_fifo
  (
    .clk      (clk),
    .rst      (rst),
    .clr      (s_r.clr),
    .wr_valid (got && fifo_on),
    .wr_data  ({dec_err, dec_char}),
    .wr_ready (rf_wr),
    .rd_valid (rf_rv),
    .rd_data  (rf_rd),
    .rd_ready (rf_rr)
  );

  // shared coder
  slc_codec u_codec
  (
    .w8       (w8),
    .coded    (coded),
    .enc_char (enc_in),
    .enc_idle (!have),
    .enc_code (enc_code),
    .dec_code (dec_code),
    .dec_char (dec_char),
    .dec_err  (dec_err),
    .dec_idle (dec_idle)
  );

  // every output straight from the state register
  assign pready          = s_r.pready;
  assign prdata          = s_r.prdata;
  assign pslverr         = s_r.pslverr;
  assign irq             = s_r.irq;
  assign tx_full         = s_r.tx_full;
  assign rx_char_bits    = s_r.rxo[11:0];
  assign rx_command_flag = s_r.rxo[12];
  assign rx_char_err     = s_r.rxo[13];
  assign rx_char_valid   = s_r.rxo_v;
  assign rx_empty        = s_r.rx_empty;
  assign serial_out      = s_r.line;
endmodule : slc_link_core

// file: pkg/slc_pkg.sv
package slc_pkg;
  // storage and character sizes
  localparam int DEPTH = 256;
  localparam int AW    = 8;
  localparam int CW    = 13;  // command flag plus 12 character bits
  localparam int EW    = 14;  // error flag plus character
  localparam int LEN8  = 10;
  localparam int LEN10 = 12;
  // clk cycles per serial bit, minus one
  localparam logic [1:0] DIV_X10 = 2'h3;
  localparam logic [1:0] DIV_X20 = 2'h1;
  // line symbols outside the data code space
  localparam logic [4:0]  SYM5_IDLE = 5'h1f;
  localparam logic [4:0]  SYM5_CMD  = 5'h18;
  localparam logic [5:0]  SYM6_IDLE = 6'h30;
  localparam logic [5:0]  SYM6_CMD  = 6'h0f;
  // five zeros never occur in coded data, so this idle marks the boundary
  localparam logic [11:0] IDLE8     = {2'h0, SYM5_IDLE, 5'h00};
  localparam logic [11:0] IDLE10    = {SYM6_IDLE, SYM6_IDLE};
  localparam logic [4:0]  ENC5 [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e,
    5'h0f, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
  localparam logic [9:0]  PAT_MASK8  = 10'h0ff;
  localparam logic [9:0]  PAT_MASK10 = 10'h3ff;
  // apb map
  localparam logic [7:0] ADDR_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_STAT  = 8'h04;
  localparam logic [7:0] ADDR_MASK  = 8'h08;
  localparam logic [7:0] ADDR_LEVEL = 8'h0c;
  localparam int CB_W8 = 0;
  localparam int CB_CODE_N = 1;
  localparam int CB_FIFO_N = 2;
  localparam int CB_FAST = 3;
  localparam int CB_BUILT_IN_PATTERN_TEST = 4;
  localparam int CB_LINE = 5;
  localparam int CB_CLR = 6;
  localparam logic [5:0] CTRL_RST = 6'h07;
  localparam int SB_CERR = 0;
  localparam int SB_RXOVF = 1;
  localparam int SB_PERR = 2;
  localparam int SB_TXOVF = 3;
  // synchroniser bundle positions
  localparam int SY_SEL = 12;
  localparam int SY_WR = 13;
  localparam int SY_RD = 14;
  localparam int SY_LA = 15;
  localparam int SY_LB = 16;
  localparam int SY_TX_FIFO_CLOCK = 17;
  localparam int SY_RXCLK = 19;
  typedef enum logic [1:0] {SER_IDLE = 2'b01, SER_CHAR = 2'b10} slc_ser_type;
  typedef enum logic [1:0] {FR_HUNT = 2'b01, FR_LOCK = 2'b10} slc_frame_type;
endpackage : slc_pkg

// file: core/slc_fifo.sv
`timescale 1ns/100ps
module slc_fifo
  import slc_pkg::*;
(
  // clock and clear
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          clr,
  // fill side
  input  wire logic          wr_valid,
  input  wire logic [EW-1:0] wr_data,
  output logic               wr_ready,
  // drain side
  output logic               rd_valid,
  output logic [EW-1:0]      rd_data,
  input  wire logic          rd_ready
);
  typedef struct packed {
    logic [DEPTH-1:0][EW-1:0] mem;
    logic [AW:0]              wp;
    logic [AW:0]              rp;
  } slc_fifo_st_type;

  slc_fifo_st_type s_r;
  slc_fifo_st_type s_nxt;

  // extra pointer bit tells full from empty
  assign wr_ready = !((s_r.wp[AW] != s_r.rp[AW]) && (s_r.wp[AW-1:0] == s_r.rp[AW-1:0]));
  assign rd_valid = (s_r.wp != s_r.rp);
  assign rd_data  = s_r.mem[s_r.rp[AW-1:0]];

  // clear drops pointers only, storage keeps stale words
  always_comb
  begin
    s_nxt = s_r;
    if (clr)
    begin
      s_nxt.wp = '0;
      s_nxt.rp = '0;
    end
    else
    begin
      if (wr_valid && wr_ready)
      begin
        s_nxt.mem[s_r.wp[AW-1:0]] = wr_data;
        s_nxt.wp = s_r.wp + 1'b1;
      end
      if (rd_valid && rd_ready)
        s_nxt.rp = s_r.rp + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end
endmodule : slc_fifo

// file: core/slc_codec.sv
`timescale 1ns/100ps
module slc_codec
  import slc_pkg::*;
(
  // mode
  input  wire logic          w8,
  input  wire logic          coded,
  // encode side
  input  wire logic [CW-1:0] enc_char,
  input  wire logic          enc_idle,
  output logic [11:0]        enc_code,
  // decode side
  input  wire logic [11:0]   dec_code,
  output logic [CW-1:0]      dec_char,
  output logic               dec_err,
  output logic               dec_idle
);
  function automatic logic [4:0] e5(input logic [3:0] n);
    e5 = ENC5[n];
  endfunction : e5

  // msb set means the symbol is not a data code
  function automatic logic [4:0] d5(input logic [4:0] c);
    d5 = 5'h10;
    for (int i = 0; i < 16; i++)
      if (c == ENC5[i])
        d5 = {1'b0, 4'(i)};
  endfunction : d5

  // odd parity appended, so even-parity symbols stay free for control
  function automatic logic [5:0] e6(input logic [4:0] d);
    e6 = {d, ~^d};
  endfunction : e6

  logic [3:0] cmd4;
  logic [4:0] h5;
  logic [4:0] l5;

  // eight-bit command pins sit below the two upper data pins, which go in swapped order
  assign cmd4 = {enc_char[8], enc_char[9], enc_char[11], enc_char[10]};
  assign h5   = d5(dec_code[9:5]);
  assign l5   = d5(dec_code[4:0]);
  assign dec_idle = w8 ? (dec_code[9:0] == IDLE8[9:0]) : (dec_code == IDLE10);

  // encoder
  always_comb
  begin
    if (enc_idle)
      enc_code = w8 ? IDLE8 : IDLE10;
    else if (!coded)
      enc_code = w8 ? {2'h0, enc_char[9:0]} : enc_char[11:0];
    else if (w8)
      enc_code = enc_char[12] ? {2'h0, SYM5_CMD, e5(cmd4)}
        : {2'h0, e5(enc_char[7:4]), e5(enc_char[3:0])};
    else
      enc_code = enc_char[12] ? {SYM6_CMD, e6({3'h0, enc_char[11:10]})}
        : {e6(enc_char[9:5]), e6(enc_char[4:0])};
  end

  // decoder and character check
  always_comb
  begin
    if (!coded)
    begin
      dec_char = {1'b0, w8 ? {2'h0, dec_code[9:0]} : dec_code};
      dec_err  = 1'b0;
    end
    else if (w8)
    begin
      dec_char = (h5 == 5'h10 && dec_code[9:5] == SYM5_CMD) ? {1'b1, 8'h00, l5[3:0]}
        : {1'b0, 4'h0, h5[3:0], l5[3:0]};
      dec_err  = (dec_code[9:5] != SYM5_CMD && h5[4]) || l5[4];
    end
    else if (dec_code[11:6] == SYM6_CMD)
    begin
      dec_char = {1'b1, 10'h000, dec_code[2:1]};
      dec_err  = ~^dec_code[5:0] || (|dec_code[5:3]);
    end
    else
    begin
      dec_char = {1'b0, 2'h0, dec_code[11:7], dec_code[5:1]};
      dec_err  = ~^dec_code[11:6] || ~^dec_code[5:0];
    end
  end
endmodule : slc_codec

// file: tb/slc_link_core_sva.sv
`timescale 1ns/100ps
module slc_link_sva
  import slc_pkg::*;
(
  // system
  input wire logic        clk,
  input wire logic        rst,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        irq,
  // flags and line
  input wire logic        tx_full,
  input wire logic        rx_empty,
  input wire logic        serial_out
);
  logic [5:0] ctrl_shadow_r;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // mode shadow, so a readback can be judged against the latest write
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      ctrl_shadow_r <= CTRL_RST;
    else if (psel && penable && pready && pwrite && paddr == ADDR_CTRL)
      ctrl_shadow_r <= pwdata[5:0];
  end
  // bus handshake and decode
  AST_READY_AFTER_SETUP: assert property (psel && !penable |=> pready)
    else $error("no ready in first access cycle");
  AST_READY_ONE_CYCLE: assert property (pready |=> !pready)
    else $error("ready held too long");
  AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
    else $error("ready outside access phase");
  AST_ERR_UNMAPPED: assert property (psel && !penable && (paddr > ADDR_LEVEL
    || paddr[1:0] != 2'h0) |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  AST_NO_ERR_MAPPED: assert property (psel && !penable && paddr <= ADDR_LEVEL
    && paddr[1:0] == 2'h0 |=> !pslverr)
    else $error("mapped access refused");
  AST_PRDATA_HOLD: assert property (!(psel && !penable) |=> $stable(prdata))
    else $error("read data moved outside setup");
  AST_CTRL_READBACK: assert property (psel && !penable && !pwrite
    && paddr == ADDR_CTRL |=> prdata == {26'h0, ctrl_shadow_r})
    else $error("mode register readback wrong");
  // interrupt, reset and line
  AST_IRQ_MASKED: assert property (psel && penable && pready && pwrite
    && paddr == ADDR_MASK && pwdata[3:0] == 4'h0 |=> ##1 !irq)
    else $error("interrupt high with mask clear");
  AST_RESET_STATE: assert property ($fell(rst) |-> rx_empty && !tx_full && !irq)
    else $error("bad state after reset");
  AST_BIT_TIME: assert property ($changed(serial_out) |=> $stable(serial_out))
    else $error("line bit shorter than two clocks");
  cover property (pslverr);
  cover property ($rose(irq));
  cover property ($rose(tx_full));
endmodule : slc_link_sva

bind slc_link_core slc_link_sva chk_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .irq(irq), .tx_full(tx_full), .rx_empty(rx_empty),
  .serial_out(serial_out));

// file: tb/slc_remote_model.sv
`timescale 1ns/100ps
module slc_remote_model
(
  // system
  input  wire logic clk,
  input  wire logic rst,
  // line from the block and far-end mode
  input  wire logic serial_out,
  input  wire logic use_b,
  input  wire logic slow,
  // lines back to the block
  output logic      rx_line_a,
  output logic      rx_line_b
);
  logic       echo_r;
  logic [2:0] noise_r;
  logic       back;
  // far end loops the stream; period 7 noise never aliases to a bit time
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      echo_r  <= 1'b0;
      noise_r <= 3'h1;
    end
    else
    begin
      echo_r  <= serial_out;
      noise_r <= {noise_r[1:0], noise_r[2] ^ noise_r[1]};
    end
  end
  // slow adds a clock of line delay; the idle input carries noise
  assign back      = slow ? echo_r : serial_out;
  assign rx_line_a = use_b ? noise_r[2] : back;
  assign rx_line_b = use_b ? back : noise_r[2];
endmodule : slc_remote_model

// file: tb/test_serial_link_codec_datapath.sv
`timescale 1ns/100ps
module test_serial_link_codec_datapath
  import slc_pkg::*;
;
  // system and apb
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  // host pins and line
  logic        tx_fifo_clock, reference_clock_in, tx_write_en, tx_command_data_select;
  logic [9:0]  tx_data_bits;
  logic [1:0]  tx_command_bits;
  logic        tx_full, rx_fifo_clock, rx_read_en, rx_command_flag, rx_char_err;
  logic        rx_char_valid, rx_empty, serial_out, rx_line_a, rx_line_b, use_b, slow;
  logic [11:0] rx_char_bits;
  int          miscompares, n_tests;

  always #25 clk = ~clk;

  slc_link_core dut_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .irq(irq), .tx_fifo_clock(tx_fifo_clock),
    .reference_clock_in(reference_clock_in), .tx_write_en(tx_write_en),
    .tx_command_data_select(tx_command_data_select), .tx_data_bits(tx_data_bits),
    .tx_command_bits(tx_command_bits), .tx_full(tx_full), .rx_fifo_clock(rx_fifo_clock),
    .rx_read_en(rx_read_en), .rx_char_bits(rx_char_bits), .rx_command_flag(rx_command_flag),
    .rx_char_err(rx_char_err), .rx_char_valid(rx_char_valid), .rx_empty(rx_empty),
    .serial_out(serial_out), .rx_line_a(rx_line_a), .rx_line_b(rx_line_b));

  slc_remote_model far_u (.clk(clk), .rst(rst), .serial_out(serial_out), .use_b(use_b),
    .slow(slow), .rx_line_a(rx_line_a), .rx_line_b(rx_line_b));

  task automatic end_of_test;
    if (miscompares == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic give_up(input logic ok);
    if (!ok)
    begin
      chk("wait bound", 0, 1);
      end_of_test();
    end
  endtask : give_up

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // one apb transfer; read data and error taken at the ready edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    give_up(pready === 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // new mode plus sync clear, then let the receiver frame on idles
  task automatic set_mode(input logic [31:0] m);
    apb(1'b1, ADDR_CTRL, m | 32'h0000_0040);
    cyc(200);
  endtask : set_mode

  // pins are synchronised, so each phase spans four clocks
  task automatic tx_put(input logic on_ref, input logic sel, input logic [1:0] c,
    input logic [9:0] d);
    tx_command_data_select <= sel;
    tx_command_bits <= c;
    tx_data_bits <= d;
    tx_write_en <= 1'b1;
    cyc(4);
    if (on_ref)
      reference_clock_in <= 1'b1;
    else
      tx_fifo_clock <= 1'b1;
    cyc(4);
    reference_clock_in <= 1'b0;
    tx_fifo_clock <= 1'b0;
    tx_write_en <= 1'b0;
    cyc(4);
  endtask : tx_put

  task automatic rx_get(input logic [11:0] mask, input logic [11:0] exp, input logic cmd);
    int n;
    n = 0;
    while (rx_empty !== 1'b0 && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    give_up(rx_empty === 1'b0);
    rx_read_en <= 1'b1;
    rx_fifo_clock <= 1'b1;
    cyc(6);
    chk("rx char", rx_char_bits & mask, exp);
    chk("rx command flag", rx_command_flag, cmd);
    chk("rx char error", rx_char_err, 0);
    chk("rx valid", rx_char_valid, 1);
    rx_fifo_clock <= 1'b0;
    rx_read_en <= 1'b0;
    cyc(4);
  endtask : rx_get

  task automatic s_reset;
    chk("reset tx_full", tx_full, 0);
    chk("reset rx_empty", rx_empty, 1);
    apb(1'b0, ADDR_CTRL, 0);
    chk("ctrl reset", rd, 32'h0000_0007);
    apb(1'b0, ADDR_LEVEL, 0);
    chk("level reset", rd & 32'h0000_ff03, 32'h0000_0002);
    apb(1'b1, 8'h10, 32'h0000_0005);
    chk("unmapped error", err, 1);
  endtask : s_reset

  // coded eight and ten bit, data then command, looped through the line
  task automatic s_coded;
    set_mode(32'h0000_0007);
    tx_put(1'b0, 1'b0, 2'h0, 10'h0a5);
    tx_put(1'b0, 1'b1, 2'h1, 10'h100);
    rx_get(12'h0ff, 12'h0a5, 1'b0);
    rx_get(12'h00f, 12'h009, 1'b1);
    set_mode(32'h0000_0006);
    tx_put(1'b0, 1'b0, 2'h0, 10'h2c3);
    tx_put(1'b0, 1'b1, 2'h2, 10'h000);
    rx_get(12'h3ff, 12'h2c3, 1'b0);
    rx_get(12'h003, 12'h002, 1'b1);
  endtask : s_coded

  task automatic s_precoded;
    set_mode(32'h0000_0005);
    tx_put(1'b0, 1'b0, 2'h0, 10'h2a5);
    rx_get(12'h3ff, 12'h2a5, 1'b0);
    set_mode(32'h0000_0004);
    tx_put(1'b0, 1'b0, 2'h2, 10'h1a6);
    rx_get(12'hfff, 12'h9a6, 1'b0);
  endtask : s_precoded

  // second line input, fast rate, far end one clock late
  task automatic s_line_b;
    use_b <= 1'b1;
    slow <= 1'b1;
    set_mode(32'h0000_002f);
    tx_put(1'b0, 1'b0, 2'h0, 10'h03c);
    rx_get(12'h0ff, 12'h03c, 1'b0);
    use_b <= 1'b0;
    slow <= 1'b0;
  endtask : s_line_b

  task automatic s_fifo_bypass;
    int n;
    n = 0;
    set_mode(32'h0000_0003);
    tx_put(1'b1, 1'b0, 2'h0, 10'h05a);
    while (rx_char_valid !== 1'b1 && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    give_up(rx_char_valid === 1'b1);
    chk("bypass char", rx_char_bits & 12'h0ff, 12'h05a);
  endtask : s_fifo_bypass

  // fill until refused, then overflow interrupt, mask, clear and sync clear
  task automatic s_overflow;
    set_mode(32'h0000_0007);
    for (int i = 0; i < 500 && tx_full !== 1'b1; i++)
      tx_put(1'b0, 1'b0, 2'h0, 10'(i & 8'hff));
    chk("tx_full", tx_full, 1);
    tx_put(1'b0, 1'b0, 2'h0, 10'h011);
    tx_put(1'b0, 1'b0, 2'h0, 10'h022);  // a drain may free one slot for the first
    apb(1'b0, ADDR_STAT, 0);
    chk("overflow status", rd & 32'h0000_0008, 32'h0000_0008);
    chk("irq masked", irq, 0);
    apb(1'b1, ADDR_MASK, 32'h0000_0008);
    cyc(3);
    chk("irq raised", irq, 1);
    apb(1'b1, ADDR_STAT, 32'h0000_0008);
    cyc(3);
    chk("irq cleared", irq, 0);
    apb(1'b1, ADDR_CTRL, 32'h0000_0047);
    cyc(3);
    chk("clear tx_full", tx_full, 0);
    chk("clear rx_empty", rx_empty, 1);
    apb(1'b1, ADDR_MASK, 0);
  endtask : s_overflow

  task automatic s_pattern;
    set_mode(32'h0000_0017);
    cyc(2000);
    apb(1'b0, ADDR_LEVEL, 0);
    chk("pattern errors", rd & 32'h0000_ff08, 32'h0000_0008);
    apb(1'b0, ADDR_STAT, 0);
    chk("pattern status", rd & 32'h0000_0004, 0);
  endtask : s_pattern

  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {tx_fifo_clock, reference_clock_in, tx_write_en, tx_command_data_select} = '0;
    {tx_data_bits, tx_command_bits, rx_fifo_clock, rx_read_en, use_b, slow} = '0;
    miscompares = 0;
    n_tests = 0;
    cyc(3);
    rst <= 1'b0;
    @(posedge clk);
    s_reset();
    s_coded();
    s_precoded();
    s_line_b();
    s_fifo_bypass();
    s_overflow();
    s_pattern();
    end_of_test();
  end
endmodule : test_serial_link_codec_datapath
